// ===== hw/ocsw_top.sv
// protected output switch: drive follow, short trip and self-healing retry
//
// Overview of operation
// R1: an over-current that ends before the trip delay has run out is ignored and the output stays on.
// R2: an over-current that lasts past the trip delay is a short and turns the output off.
// R3: after a short trip the block waits the retry time and then turns the output on again.
// R4: if the over-current is present at a retry the output goes off at once, without a new delay.
// R5: the trip and retry cycle repeats until the short clears, the request drops or power goes.
// R6: software must set the retry wait above 1,000 times the trip delay when no external switch is used.
// R7: with the sense strap high the block runs as a sink driver with the internal switch.
// R8: with the sense strap low the block runs as a source driver for an external transistor.
// R9: a sense drop above the comparator threshold turns the output stage off after the trip delay.
// R10: with no fault the load output follows the drive request level.
// R11: the controller holds the drive request low during power-up; an internal pull-down helps.
// R12: at power-on default trip delay and retry codes are restored; codes may change at any time.
// R13: the comparator result is synchronised and the delays are timed with clock-derived counters.
`timescale 1ns/1ps
`include "ocsw_consts.svh"
module ocsw_top
	import ocsw_pkg::*;
#(
	parameter int CLK_HZ = `OCSW_CLK_HZ,
	parameter int TICKS_PER_US = CLK_HZ / 1000000,
	parameter int US_PER_MS = 1000
)
(
	input wire logic i_clock,
	input wire logic i_rstn,
	input wire logic i_drive_req,
	input wire logic i_overcurrent,
	input wire logic i_sense_strap,
	input wire logic [7:0] i_awaddr,
	input wire logic i_awvalid,
	output logic o_awready,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	input wire logic i_wvalid,
	output logic o_wready,
	output logic [1:0] o_bresp,
	output logic o_bvalid,
	input wire logic i_bready,
	input wire logic [7:0] i_araddr,
	input wire logic i_arvalid,
	output logic o_arready,
	output logic [31:0] o_rdata,
	output logic [1:0] o_rresp,
	output logic o_rvalid,
	input wire logic i_rready,
	output logic o_sink_drive,
	output logic o_source_drive,
	output logic o_irq
);
	// ------------------------------------------------------------
	// input synchronisation
	// ------------------------------------------------------------
	logic [2:0] pins_sync;
	logic req, oc, strap;

	// pins cross into the clock domain before use
	ocsw_sync #(.WIDTH(3)) u_sync
	(
		.i_clock(i_clock),
		.i_rstn(i_rstn),
		.i_async({i_drive_req, i_overcurrent, i_sense_strap}),
		.o_sync(pins_sync)
	); // R13
	assign req = pins_sync[2];
	assign oc = pins_sync[1];
	assign strap = pins_sync[0];

	// ------------------------------------------------------------
	// register file
	// ------------------------------------------------------------
	ocsw_cfg_s cfg;
	ocsw_evt_s evt;
	logic [7:0] status;
	ocsw_state_e state, next_state;
	logic sink_mode;

	ocsw_axil u_regs
	(
		.i_clock(i_clock),
		.i_rstn(i_rstn),
		.i_awaddr(i_awaddr),
		.i_awvalid(i_awvalid),
		.o_awready(o_awready),
		.i_wdata(i_wdata),
		.i_wstrb(i_wstrb),
		.i_wvalid(i_wvalid),
		.o_wready(o_wready),
		.o_bresp(o_bresp),
		.o_bvalid(o_bvalid),
		.i_bready(i_bready),
		.i_araddr(i_araddr),
		.i_arvalid(i_arvalid),
		.o_arready(o_arready),
		.o_rdata(o_rdata),
		.o_rresp(o_rresp),
		.o_rvalid(o_rvalid),
		.i_rready(i_rready),
		.i_status(status),
		.i_evt(evt),
		.o_cfg(cfg),
		.o_irq(o_irq)
	);

	// ------------------------------------------------------------
	// timebase
	// ------------------------------------------------------------
	// one-cycle microsecond enable from a divider
	logic [15:0] div, next_div;
	logic us_tick;

	always_comb
	begin
		us_tick = (div == 16'(TICKS_PER_US - 1));
		next_div = us_tick ? 16'h0000 : div + 16'h0001;
	end

	always_ff @(posedge i_clock or negedge i_rstn)
	begin
		if (!i_rstn)
			div <= 16'h0000;
		else
			div <= next_div; // R13
	end

	// ------------------------------------------------------------
	// mode strap
	// ------------------------------------------------------------
	// the strap is read once both synchroniser stages hold the pin level;
	// a later change cannot swap the drive stage under load
	logic [1:0] settle, next_settle;
	logic strap_taken, next_strap_taken;
	logic next_sink_mode;

	// settle count, then one capture of the strap level
	always_comb
	begin
		next_settle = settle;
		next_strap_taken = strap_taken;
		next_sink_mode = sink_mode;
		if (!strap_taken)
		begin
			next_sink_mode = strap; // R7 R8
			if (settle == 2'(`OCSW_STRAP_SETTLE))
				next_strap_taken = 1'b1;
			else
				next_settle = settle + 2'h1;
		end
	end

	always_ff @(posedge i_clock or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			settle <= 2'h0;
			strap_taken <= 1'b0;
			sink_mode <= 1'b0;
		end
		else
		begin
			settle <= next_settle;
			strap_taken <= next_strap_taken;
			sink_mode <= next_sink_mode;
		end
	end

	// trip delay code to microseconds
	function automatic logic [23:0] del_us(input logic [2:0] code);
		unique case (code)
			3'h0: del_us = 24'(`OCSW_DEL_US_0);
			3'h1: del_us = 24'(`OCSW_DEL_US_1);
			3'h2: del_us = 24'(`OCSW_DEL_US_2);
			3'h3: del_us = 24'(`OCSW_DEL_US_3);
			3'h4: del_us = 24'(`OCSW_DEL_US_4);
			3'h5: del_us = 24'(`OCSW_DEL_US_5);
			3'h6: del_us = 24'(`OCSW_DEL_US_6);
			3'h7: del_us = 24'(`OCSW_DEL_US_7);
		endcase
	endfunction

	// retry wait code to microseconds
	function automatic logic [23:0] rec_us(input logic [2:0] code);
		logic [23:0] ms;
		unique case (code)
			3'h0: ms = 24'(`OCSW_REC_MS_0);
			3'h1: ms = 24'(`OCSW_REC_MS_1);
			3'h2: ms = 24'(`OCSW_REC_MS_2);
			3'h3: ms = 24'(`OCSW_REC_MS_3);
			3'h4: ms = 24'(`OCSW_REC_MS_4);
			3'h5: ms = 24'(`OCSW_REC_MS_5);
			3'h6: ms = 24'(`OCSW_REC_MS_6);
			3'h7: ms = 24'(`OCSW_REC_MS_7);
		endcase
		rec_us = 24'(ms * 24'(US_PER_MS));
	endfunction

	// ------------------------------------------------------------
	// switch control
	// ------------------------------------------------------------
	logic [23:0] cnt, next_cnt;
	logic out_on, next_out_on;
	logic trip_ev, retry_ev, clear_ev;

	always_comb
	begin
		next_state = state;
		next_cnt = cnt;
		trip_ev = 1'b0;
		retry_ev = 1'b0;
		clear_ev = 1'b0;
		unique case (state)
			OCSW_IDLE:
			begin
				next_cnt = 24'h000000;
				if (req)
					next_state = OCSW_ON; // R10
			end
			OCSW_ON:
			begin
				if (!req)
					next_state = OCSW_IDLE; // R10
				else if (!oc)
					next_cnt = 24'h000000; // R1
				else if (us_tick)
				begin
					if (cnt + 24'h000001 >= del_us(cfg.del_code))
					begin
						next_state = OCSW_OFF_WAIT; // R2 R9
						next_cnt = 24'h000000;
						trip_ev = 1'b1;
					end
					else
						next_cnt = cnt + 24'h000001;
				end
			end
			OCSW_OFF_WAIT:
			begin
				if (!req)
					next_state = OCSW_IDLE; // R5
				else if (us_tick)
				begin
					if (cnt + 24'h000001 >= rec_us(cfg.rec_code))
					begin
						next_state = OCSW_RETRY; // R3
						next_cnt = 24'h000000;
						retry_ev = 1'b1;
					end
					else
						next_cnt = cnt + 24'h000001;
				end
			end
			OCSW_RETRY:
			begin
				// output on for one probe; sense settles through the synchroniser
				if (!req)
					next_state = OCSW_IDLE; // R5
				else if (cnt < 24'(`OCSW_PROBE_WAIT))
					next_cnt = cnt + 24'h000001;
				else if (oc)
				begin
					next_state = OCSW_OFF_WAIT; // R4
					next_cnt = 24'h000000;
				end
				else
				begin
					next_state = OCSW_ON; // R5
					next_cnt = 24'h000000;
					clear_ev = 1'b1;
				end
			end
		endcase
		next_out_on = (next_state == OCSW_ON) || (next_state == OCSW_RETRY);
	end

	always_ff @(posedge i_clock or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			state <= OCSW_IDLE;
			cnt <= 24'h000000;
			out_on <= 1'b0;
			o_sink_drive <= 1'b0;
			o_source_drive <= 1'b0;
		end
		else
		begin
			state <= next_state;
			cnt <= next_cnt;
			out_on <= next_out_on;
			o_sink_drive <= next_out_on & next_sink_mode; // R7
			o_source_drive <= next_out_on & ~next_sink_mode; // R8
		end
	end

	// ------------------------------------------------------------
	// status and events
	// ------------------------------------------------------------
	// one-cycle event strobes and the live status word for the bus
	always_comb
	begin
		evt = '{trip: trip_ev, retry: retry_ev, clear: clear_ev};
		status = {2'h0, sink_mode, req, oc, out_on, state};
	end
endmodule

// ===== hw/ocsw_consts.svh
// timing constants, strap and register map for the protected output switch
`ifndef OCSW_CONSTS_SVH
`define OCSW_CONSTS_SVH
`define OCSW_CLK_HZ 40000000
`define OCSW_DEL_US_0 50
`define OCSW_DEL_US_1 5
`define OCSW_DEL_US_2 10
`define OCSW_DEL_US_3 20
`define OCSW_DEL_US_4 100
`define OCSW_DEL_US_5 200
`define OCSW_DEL_US_6 500
`define OCSW_DEL_US_7 1000
`define OCSW_REC_MS_0 500
`define OCSW_REC_MS_1 10
`define OCSW_REC_MS_2 20
`define OCSW_REC_MS_3 50
`define OCSW_REC_MS_4 100
`define OCSW_REC_MS_5 200
`define OCSW_REC_MS_6 1000
`define OCSW_REC_MS_7 1500
`define OCSW_DEL_RST 3'h0
`define OCSW_REC_RST 3'h0
`define OCSW_WAIT_TO_DELAY_FACTOR 1000
`define OCSW_PROBE_WAIT 3
`define OCSW_STRAP_SETTLE 2
`define OCSW_ADDR_CTRL 8'h00
`define OCSW_ADDR_STAT 8'h04
`define OCSW_ADDR_IRQ 8'h08
`define OCSW_ADDR_MASK 8'h0C
`define OCSW_CTRL_DEL_LSB 0
`define OCSW_CTRL_REC_LSB 4
`define OCSW_IRQ_TRIP 0
`define OCSW_IRQ_RETRY 1
`define OCSW_IRQ_CLEAR 2
`endif

// ===== hw/ocsw_pkg.sv
// types shared by the protected output switch files
package ocsw_pkg;
	typedef enum logic [1:0]
	{
		OCSW_IDLE = 2'b00,
		OCSW_ON = 2'b01,
		OCSW_OFF_WAIT = 2'b10,
		OCSW_RETRY = 2'b11
	} ocsw_state_e;
	typedef struct packed
	{
		logic [2:0] del_code;
		logic [2:0] rec_code;
	} ocsw_cfg_s;
	typedef struct packed
	{
		logic trip;
		logic retry;
		logic clear;
	} ocsw_evt_s;
endpackage

// ===== hw/ocsw_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module ocsw_sync
	import ocsw_pkg::*;
#(
	parameter int WIDTH = 1
)
(
	input wire logic i_clock,
	input wire logic i_rstn,
	input wire logic [WIDTH-1:0] i_async,
	output logic [WIDTH-1:0] o_sync
);
	logic [WIDTH-1:0] meta;
	// first stage feeds only the second
	always_ff @(posedge i_clock or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			meta <= '0;
			o_sync <= '0;
		end
		else
		begin
			meta <= i_async;
			o_sync <= meta;
		end
	end
endmodule

// ===== hw/ocsw_axil.sv
// axi4-lite slave holding control, status, event and mask registers
`timescale 1ns/1ps
`include "ocsw_consts.svh"
module ocsw_axil
	import ocsw_pkg::*;
(
	input wire logic i_clock,
	input wire logic i_rstn,
	input wire logic [7:0] i_awaddr,
	input wire logic i_awvalid,
	output logic o_awready,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	input wire logic i_wvalid,
	output logic o_wready,
	output logic [1:0] o_bresp,
	output logic o_bvalid,
	input wire logic i_bready,
	input wire logic [7:0] i_araddr,
	input wire logic i_arvalid,
	output logic o_arready,
	output logic [31:0] o_rdata,
	output logic [1:0] o_rresp,
	output logic o_rvalid,
	input wire logic i_rready,
	input wire logic [7:0] i_status,
	input wire ocsw_evt_s i_evt,
	output ocsw_cfg_s o_cfg,
	output logic o_irq
);
	logic aw_got, w_got;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic [2:0] events, mask;
	logic next_aw_got, next_w_got, next_bvalid, next_rvalid, next_irq;
	logic [7:0] next_aw_addr;
	logic [31:0] next_w_data, next_rdata;
	logic [3:0] next_w_strb;
	logic [1:0] next_bresp, next_rresp;
	logic [2:0] next_events, next_mask;
	ocsw_cfg_s next_cfg;
	logic wr_fire, rd_fire, rd_clr;
	logic [2:0] evt_bits;

	// address and data taken in either order, one write at a time
	always_comb
	begin
		evt_bits = {i_evt.clear, i_evt.retry, i_evt.trip};
		next_aw_got = aw_got;
		next_w_got = w_got;
		next_aw_addr = aw_addr;
		next_w_data = w_data;
		next_w_strb = w_strb;
		next_bvalid = o_bvalid;
		next_bresp = o_bresp;
		next_rvalid = o_rvalid;
		next_rdata = o_rdata;
		next_rresp = o_rresp;
		next_cfg = o_cfg;
		next_mask = mask;
		rd_clr = 1'b0;
		if (i_awvalid && o_awready)
		begin
			next_aw_got = 1'b1;
			next_aw_addr = i_awaddr;
		end
		if (i_wvalid && o_wready)
		begin
			next_w_got = 1'b1;
			next_w_data = i_wdata;
			next_w_strb = i_wstrb;
		end
		wr_fire = aw_got && w_got && !o_bvalid;
		if (wr_fire)
		begin
			next_aw_got = 1'b0;
			next_w_got = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = 2'h0;
			if (aw_addr == `OCSW_ADDR_CTRL)
			begin
				if (w_strb[0])
				begin
					next_cfg.del_code = w_data[`OCSW_CTRL_DEL_LSB +: 3];
					next_cfg.rec_code = w_data[`OCSW_CTRL_REC_LSB +: 3];
				end
			end
			else if (aw_addr == `OCSW_ADDR_MASK)
			begin
				if (w_strb[0])
					next_mask = w_data[2:0];
			end
			else if (aw_addr != `OCSW_ADDR_STAT && aw_addr != `OCSW_ADDR_IRQ)
				next_bresp = 2'h2;
		end
		else if (o_bvalid && i_bready)
			next_bvalid = 1'b0;
		rd_fire = i_arvalid && o_arready;
		if (rd_fire)
		begin
			next_rvalid = 1'b1;
			next_rresp = 2'h0;
			next_rdata = 32'h0000_0000;
			unique case (i_araddr)
				`OCSW_ADDR_CTRL: next_rdata = {25'h0, o_cfg.rec_code, 1'b0, o_cfg.del_code};
				`OCSW_ADDR_STAT: next_rdata = {24'h0, i_status};
				`OCSW_ADDR_IRQ:
				begin
					next_rdata = {29'h0, events};
					rd_clr = 1'b1;
				end
				`OCSW_ADDR_MASK: next_rdata = {29'h0, mask};
				default: next_rresp = 2'h2;
			endcase
		end
		else if (o_rvalid && i_rready)
			next_rvalid = 1'b0;
		// a new event wins over the read clear
		next_events = (rd_clr ? 3'h0 : events) | evt_bits;
		next_irq = |(next_events & next_mask);
	end

	// register stage for the bus slave
	always_ff @(posedge i_clock or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			aw_got <= 1'b0;
			w_got <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			o_bvalid <= 1'b0;
			o_bresp <= 2'h0;
			o_rvalid <= 1'b0;
			o_rdata <= 32'h0000_0000;
			o_rresp <= 2'h0;
			o_cfg <= {`OCSW_DEL_RST, `OCSW_REC_RST}; // R12
			mask <= 3'h0;
			events <= 3'h0;
			o_irq <= 1'b0;
			o_awready <= 1'b1;
			o_wready <= 1'b1;
			o_arready <= 1'b1;
		end
		else
		begin
			aw_got <= next_aw_got;
			w_got <= next_w_got;
			aw_addr <= next_aw_addr;
			w_data <= next_w_data;
			w_strb <= next_w_strb;
			o_bvalid <= next_bvalid;
			o_bresp <= next_bresp;
			o_rvalid <= next_rvalid;
			o_rdata <= next_rdata;
			o_rresp <= next_rresp;
			o_cfg <= next_cfg; // R12
			mask <= next_mask;
			events <= next_events;
			o_irq <= next_irq;
			o_awready <= !next_aw_got; // free again once the held address is used
			o_wready <= !next_w_got;
			o_arready <= !next_rvalid;
		end
	end

endmodule

// ===== sim/ocsw_load.sv
// load model: sense comparator result seen by the switch
`timescale 1ns/1ps
module ocsw_load
(
	input wire logic i_clock,
	input wire logic i_sink_drive,
	input wire logic i_source_drive,
	input wire logic i_short,
	input wire logic [7:0] i_peak,
	output logic o_overcurrent
);
	logic on_d = 1'b0;
	logic [7:0] left = 8'h00;
	logic oc_q = 1'b0;
	wire logic on = i_sink_drive | i_source_drive;

	// inrush peak after each turn-on, then the short level
	always @(posedge i_clock)
	begin
		on_d <= on;
		if (on && !on_d)
			left <= i_peak;
		else if (left != 8'h00)
			left <= left - 8'h01;
		oc_q <= on && (i_short || left != 8'h00);
	end

	assign o_overcurrent = oc_q;
endmodule

// ===== sim/ocsw_sva.sv
// port assertions for the protected output switch
`timescale 1ns/1ps
module ocsw_sva
#(
	parameter int TICKS_PER_US = 40
)
(
	input wire logic i_clock,
	input wire logic i_rstn,
	input wire logic i_drive_req,
	input wire logic i_overcurrent,
	input wire logic i_sense_strap,
	input wire logic i_bready,
	input wire logic i_rready,
	input wire logic o_bvalid,
	input wire logic [1:0] o_bresp,
	input wire logic o_rvalid,
	input wire logic [31:0] o_rdata,
	input wire logic o_sink_drive,
	input wire logic o_source_drive
);
	localparam int TRIP_MAX = 1000 * TICKS_PER_US + 8;
	int oc_run;
	int oc_on;
	wire logic drv = o_sink_drive | o_source_drive;

	// runs of over-current, in total and with the output on
	always_ff @(posedge i_clock or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			oc_run <= 0;
			oc_on <= 0;
		end
		else
		begin
			oc_run <= i_overcurrent ? oc_run + 1 : 0;
			oc_on <= (i_overcurrent && drv) ? oc_on + 1 : 0;
		end
	end

	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (!i_rstn);

	sequence s_req_on;
		$rose(i_drive_req) ##1 (i_drive_req && !i_overcurrent) [*5];
	endsequence
	sequence s_req_off;
		!i_drive_req [*5];
	endsequence

	a_mode_exclusive: assert property (!(o_sink_drive && o_source_drive))
		else $error("both drives high");
	a_sink_only: assert property (i_sense_strap [*8] |-> !o_source_drive)
		else $error("source drive in sink mode");
	a_source_only: assert property (!i_sense_strap [*8] |-> !o_sink_drive)
		else $error("sink drive in source mode");
	a_follow_request: assert property (s_req_on |-> drv)
		else $error("output did not follow request");
	a_drop_request: assert property (s_req_off |-> !drv)
		else $error("output on without request");
	a_trip_bound: assert property (oc_on <= TRIP_MAX)
		else $error("over-current never tripped");
	a_no_early_fall: assert property (i_drive_req [*6] ##0 $fell(drv) |-> oc_run >= 2)
		else $error("output fell without over-current");
	a_bresp_hold: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
		else $error("write response dropped");
	a_rdata_hold: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
		else $error("read data dropped");
endmodule

bind ocsw_top ocsw_sva #(.TICKS_PER_US(TICKS_PER_US)) u_sva (.i_clock(i_clock),
	.i_rstn(i_rstn), .i_drive_req(i_drive_req), .i_overcurrent(i_overcurrent),
	.i_sense_strap(i_sense_strap), .i_bready(i_bready), .i_rready(i_rready),
	.o_bvalid(o_bvalid), .o_bresp(o_bresp), .o_rvalid(o_rvalid), .o_rdata(o_rdata),
	.o_sink_drive(o_sink_drive), .o_source_drive(o_source_drive));

// ===== sim/test_ocsw_top.sv
// self-checking bench for the protected output switch
`timescale 1ns/1ps
module test_ocsw_top;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic req = 1'b0;
	logic strap = 1'b1;
	logic short = 1'b0;
	logic [7:0] peak = 8'h00;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic arvalid = 1'b0;
	logic bready = 1'b0;
	logic rready = 1'b0;
	logic slow = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, sink, source, irq;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	wire logic oc;
	wire logic drv = sink | source;
	int fails = 0;
	int compares = 0;
	int cycles = 0;

	// 40 MHz clock
	always #12.5 clk = ~clk;

	ocsw_top #(.TICKS_PER_US(4), .US_PER_MS(1)) dut (.i_clock(clk), .i_rstn(rstn),
		.i_drive_req(req), .i_overcurrent(oc), .i_sense_strap(strap),
		.i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata),
		.i_wstrb(4'hF), .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp),
		.o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
		.o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
		.i_rready(rready), .o_sink_drive(sink), .o_source_drive(source), .o_irq(irq));

	ocsw_load load (.i_clock(clk), .i_sink_drive(sink), .i_source_drive(source),
		.i_short(short), .i_peak(peak), .o_overcurrent(oc));

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic summarize;
		$display("comparisons %0d mismatches %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		compares++;
		if (s !== e)
		begin
			fails++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic rng(input string nm, input int lo, input int hi, input int c);
		compares++;
		if (c < lo || c > hi)
		begin
			fails++;
			$display("Error %s expected %0d..%0d seen %0d", nm, lo, hi, c);
		end
	endtask

	// write with address and data offered together
	// slow keeps the response ready low until the answer has been seen once
	task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= !slow;
		do
		begin
			@(posedge clk);
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
			if (bvalid && !bready)
				bready <= 1'b1;
		end
		while (!(bvalid && bready));
		r = bresp;
	endtask

	task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= !slow;
		do
		begin
			@(posedge clk);
			if (arvalid && arready)
				arvalid <= 1'b0;
			if (rvalid && !rready)
				rready <= 1'b1;
		end
		while (!(rvalid && rready));
		d = rdata;
		r = rresp;
	endtask

	// cycles until the output reaches level v
	task automatic wdrv(input logic v, input int lim, output int c);
		c = 0;
		while (drv !== v && c < lim)
		begin
			@(posedge clk);
			c++;
		end
	endtask

	// output must keep level v for n cycles
	task automatic hold(input string nm, input logic v, input int n);
		int c;
		c = 0;
		repeat (n)
		begin
			@(posedge clk);
			if (drv !== v)
				c++;
		end
		rng(nm, 0, 0, c);
	endtask

	task automatic do_reset(input logic s);
		rstn <= 1'b0;
		req <= 1'b0;
		strap <= s;
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		repeat (6) @(posedge clk);
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_regs;
		logic [31:0] d;
		logic [1:0] r;
		axr(8'h00, d, r);
		chk("ctrl reset", 32'h0, d);
		axr(8'h0C, d, r);
		chk("mask reset", 32'h0, d);
		axw(8'h00, 32'h11, r);
		axr(8'h00, d, r);
		chk("ctrl write", 32'h11, d);
		slow = 1'b1;
		axw(8'h10, 32'h55, r);
		chk("bad write", 32'h2, {30'h0, r});
		axr(8'h10, d, r);
		chk("bad read", 32'h2, d | {30'h0, r});
		slow = 1'b0;
		$display("register test done");
	endtask

	task automatic t_follow;
		int c;
		req <= 1'b1;
		wdrv(1'b1, 20, c);
		rng("turn on", 1, 8, c);
		chk("sink only", 32'h1, {31'h0, sink & !source});
		req <= 1'b0;
		wdrv(1'b0, 20, c);
		rng("turn off", 1, 8, c);
		$display("follow test done");
	endtask

	task automatic t_peak;
		int c;
		peak <= 8'h0A;
		req <= 1'b1;
		wdrv(1'b1, 20, c);
		hold("peak ignored", 1'b1, 60);
		peak <= 8'h00;
		$display("peak test done");
	endtask

	task automatic t_trip;
		int c;
		logic [31:0] d;
		logic [1:0] r;
		short <= 1'b1;
		wdrv(1'b0, 100, c);
		rng("trip delay", 16, 30, c);
		chk("irq masked", 32'h0, {31'h0, irq});
		wdrv(1'b1, 100, c);
		rng("retry wait", 36, 50, c);
		wdrv(1'b0, 20, c);
		rng("retry off", 1, 8, c);
		axw(8'h0C, 32'h7, r);
		repeat (2) @(posedge clk);
		chk("irq raised", 32'h1, {31'h0, irq});
		axr(8'h08, d, r);
		chk("events", 32'h3, d & 32'h3);
		repeat (2) @(posedge clk);
		chk("irq cleared", 32'h0, {31'h0, irq});
		$display("trip test done");
	endtask

	task automatic t_heal;
		int c;
		logic [31:0] d;
		logic [1:0] r;
		short <= 1'b0;
		wdrv(1'b1, 100, c);
		rng("heal retry", 5, 50, c);
		hold("stay on", 1'b1, 60);
		axr(8'h08, d, r);
		chk("heal event", 32'h4, d & 32'h4);
		short <= 1'b1;
		wdrv(1'b0, 100, c);
		rng("retrip", 16, 30, c);
		req <= 1'b0;
		hold("no retry", 1'b0, 80);
		short <= 1'b0;
		req <= 1'b1;
		wdrv(1'b1, 20, c);
		rng("on again", 1, 8, c);
		$display("heal test done");
	endtask

	task automatic t_source;
		int c;
		logic [31:0] d;
		logic [1:0] r;
		do_reset(1'b0);
		axr(8'h00, d, r);
		chk("ctrl default", 32'h0, d);
		req <= 1'b1;
		wdrv(1'b1, 20, c);
		rng("source on", 1, 8, c);
		chk("source only", 32'h1, {31'h0, source & !sink});
		short <= 1'b1;
		wdrv(1'b0, 300, c);
		rng("default trip", 190, 215, c);
		short <= 1'b0;
		req <= 1'b0;
		$display("source test done");
	endtask

	initial
	begin
		do_reset(1'b1);
		t_regs;
		t_follow;
		t_peak;
		t_trip;
		t_heal;
		t_source;
		summarize;
	end

	// hang guard
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 10000)
		begin
			fails++;
			summarize;
		end
	end
endmodule
